// file: pbm_bus_match.sv
// Port B bus matching, read flag timing and APB control for two queues.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pbm_bus_match #(
  parameter int DEPTH_LOG2 = pbm_pkg::DEPTH_LOG2
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pbm_pkg::APB_AW-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          masterResetOneN,
  input  wire logic                          masterResetTwoN,
  input  wire logic                          endianSelect,
  input  wire logic                          portaWrEn,
  input  wire logic [pbm_pkg::LWORD_W-1:0]   portaWrData,
  input  wire logic                          portaRdEn,
  output logic      [pbm_pkg::LWORD_W-1:0]   portaRdData,
  output logic                               portaEmptyFlag,
  output logic                               portaOutputReady,
  input  wire logic                          portbWrEn,
  input  wire logic [pbm_pkg::LWORD_W-1:0]   portbWrData,
  input  wire logic                          portbRdEn,
  output logic      [pbm_pkg::LWORD_W-1:0]   portbRdData,
  output logic                               portbEmptyFlag,
  output logic                               portbOutputReady
);

  localparam int LW = pbm_pkg::LWORD_W;
  localparam int WW = pbm_pkg::WORD_W;
  localparam int BW = pbm_pkg::BYTE_W;
  localparam int AB = pbm_pkg::DIR_AB;
  localparam int BA = pbm_pkg::DIR_BA;

  // Pick one lane of a long word, placed in the low bits, upper bits zero.
  function automatic logic [LW-1:0] laneGet(
    input logic [LW-1:0]         word,
    input pbm_pkg::pbm_size_t    mode,
    input logic [1:0]            idx
  );
    logic [LW-1:0] res;
    res = '0;
    case (mode)
      pbm_pkg::SIZE_WORD: res[WW-1:0] = word[idx*WW +: WW];
      pbm_pkg::SIZE_BYTE: res[BW-1:0] = word[idx*BW +: BW];
      default:            res = word;
    endcase
    return res;
  endfunction

  logic [2:0]              pinSync;
  logic                    mrOneRel;
  logic                    mrTwoRel;
  logic                    endianPin;
  logic                    bothRel;
  logic                    bothPrev_q;
  logic                    bothPrev_d;
  logic                    endian_q;
  logic                    endian_d;
  logic                    bm_q;
  logic                    bm_d;
  logic                    size_q;
  logic                    size_d;
  logic                    fall_q;
  logic                    fall_d;
  logic                    prstAb_q;
  logic                    prstAb_d;
  logic                    prstBa_q;
  logic                    prstBa_d;
  logic                    flush [2];
  pbm_pkg::pbm_size_t      busSize;
  logic [31:0]             prdata_d;
  logic                    pready_d;
  logic                    pslverr_d;
  logic                    apbSetup;
  logic                    apbWrite;
  logic [31:0]             statusWord;
  logic [31:0]             levelWord;
  logic [LW-1:0]           head [2];
  logic                    headValid [2];
  logic                    hasSecond [2];
  logic                    qFull [2];
  logic [DEPTH_LOG2:0]     qLevel [2];
  logic                    pop [2];
  logic                    rdReq [2];
  pbm_pkg::pbm_size_t      mode [2];
  logic [1:0]              last [2];
  logic [LW-1:0]           rdData_q [2];
  logic [LW-1:0]           rdData_d [2];
  logic [LW-1:0]           held_q [2];
  logic [LW-1:0]           held_d [2];
  logic [1:0]              pos_q [2];
  logic [1:0]              pos_d [2];
  logic                    emp_q [2];
  logic                    emp_d [2];
  logic                    rdy_q [2];
  logic                    rdy_d [2];
  logic [LW-1:0]           asm_q;
  logic [LW-1:0]           asm_d;
  logic [1:0]              asmPos_q;
  logic [1:0]              asmPos_d;
  logic                    commit;
  logic [LW-1:0]           commitData;

  // Reset and endian pins come from outside and are synchronised first.
  pbm_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h0)
  ) u_pin_sync (
    .clk     (clk),
    .rst     (rst),
    .pinIn   ({endianSelect, masterResetTwoN, masterResetOneN}),
    .syncOut (pinSync)
  );

  // Released levels of the two master resets and the endian pin.
  assign mrOneRel  = pinSync[0];
  assign mrTwoRel  = pinSync[1];
  assign endianPin = pinSync[2];
  assign bothRel   = mrOneRel && mrTwoRel;

  // Each queue is cleared by its master reset or a software partial reset.
  assign flush[AB] = !mrOneRel || prstAb_q;
  assign flush[BA] = !mrTwoRel || prstBa_q;

  // Port B bus size from the two static select bits.
  always_comb begin
    if (!bm_q) begin
      busSize = pbm_pkg::SIZE_LONG;
    end else if (size_q) begin
      busSize = pbm_pkg::SIZE_BYTE;
    end else begin
      busSize = pbm_pkg::SIZE_WORD;
    end
  end

  // The A-to-B reader faces Port B; the B-to-A reader always sees long words.
  assign mode[AB]  = busSize;
  assign mode[BA]  = pbm_pkg::SIZE_LONG;
  assign rdReq[AB] = portbRdEn;
  assign rdReq[BA] = portaRdEn;

  // Status and level words for software.
  always_comb begin
    statusWord = '0;
    statusWord[pbm_pkg::ST_AB_FLAG] = fall_q ? rdy_q[AB] : emp_q[AB];
    statusWord[pbm_pkg::ST_BA_FLAG] = fall_q ? rdy_q[BA] : emp_q[BA];
    statusWord[pbm_pkg::ST_AB_FULL] = qFull[AB];
    statusWord[pbm_pkg::ST_BA_FULL] = qFull[BA];
    statusWord[pbm_pkg::ST_ENDIAN]  = endian_q;
    statusWord[pbm_pkg::ST_RD_POS +: 2]  = pos_q[AB];
    statusWord[pbm_pkg::ST_ASM_POS +: 2] = asmPos_q;
    levelWord = '0;
    levelWord[DEPTH_LOG2:0] = qLevel[AB];
    levelWord[pbm_pkg::LEVEL_BA_LSB +: DEPTH_LOG2+1] = qLevel[BA];
  end

  // APB slave: answer prepared in setup, pready high for one access cycle.
  always_comb begin
    apbSetup  = psel && !penable;
    apbWrite  = psel && penable && pready && pwrite;
    pready_d  = apbSetup;
    prdata_d  = prdata;
    pslverr_d = pslverr;
    bm_d      = bm_q;
    size_d    = size_q;
    fall_d    = fall_q;
    prstAb_d  = 1'b0;
    prstBa_d  = 1'b0;
    if (apbSetup) begin
      pslverr_d = 1'b0;
      case (paddr)
        pbm_pkg::CTRL_OFS: begin
          prdata_d = '0;
          prdata_d[pbm_pkg::CTRL_BM]   = bm_q;
          prdata_d[pbm_pkg::CTRL_SIZE] = size_q;
          prdata_d[pbm_pkg::CTRL_FALL] = fall_q;
        end
        pbm_pkg::STATUS_OFS: prdata_d = statusWord;
        pbm_pkg::LEVEL_OFS:  prdata_d = levelWord;
        default: begin
          prdata_d  = '0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    // Size selects are software held static once traffic has started.
    if (apbWrite && paddr == pbm_pkg::CTRL_OFS) begin
      bm_d     = pwdata[pbm_pkg::CTRL_BM];
      size_d   = pwdata[pbm_pkg::CTRL_SIZE];
      fall_d   = pwdata[pbm_pkg::CTRL_FALL];
      prstAb_d = pwdata[pbm_pkg::CTRL_PRST_AB];
      prstBa_d = pwdata[pbm_pkg::CTRL_PRST_BA];
    end
  end

  // Endian level is caught on the cycle both master resets are released.
  always_comb begin
    bothPrev_d = bothRel;
    endian_d   = (bothRel && !bothPrev_q) ? endianPin : endian_q;
  end

  // Configuration and APB answer registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      bm_q       <= 1'b0;
      size_q     <= 1'b0;
      fall_q     <= 1'b0;
      prstAb_q   <= 1'b0;
      prstBa_q   <= 1'b0;
      bothPrev_q <= 1'b0;
      endian_q   <= 1'b0;
    end else begin
      prdata     <= prdata_d;
      pready     <= pready_d;
      pslverr    <= pslverr_d;
      bm_q       <= bm_d;
      size_q     <= size_d;
      fall_q     <= fall_d;
      prstAb_q   <= prstAb_d;
      prstBa_q   <= prstBa_d;
      bothPrev_q <= bothPrev_d;
      endian_q   <= endian_d;
    end
  end

  // Port B write assembly; lanes are gathered until the long word is whole.
  always_comb begin
    logic [1:0] lastB;
    logic [1:0] idx;
    lastB      = (busSize == pbm_pkg::SIZE_BYTE) ? pbm_pkg::LAST_BYTE :
                 (busSize == pbm_pkg::SIZE_WORD) ? pbm_pkg::LAST_WORD :
                 pbm_pkg::LAST_LONG;
    idx        = endian_q ? lastB - asmPos_q : asmPos_q;
    commitData = asm_q;
    case (busSize)
      pbm_pkg::SIZE_WORD: commitData[idx*WW +: WW] = portbWrData[WW-1:0];
      pbm_pkg::SIZE_BYTE: commitData[idx*BW +: BW] = portbWrData[BW-1:0];
      default:            commitData = portbWrData;
    endcase
    commit   = 1'b0;
    asm_d    = asm_q;
    asmPos_d = asmPos_q;
    if (flush[BA]) begin
      asm_d    = '0;
      asmPos_d = 2'h0;
    end else if (portbWrEn && !qFull[BA]) begin
      asm_d = commitData;
      if (asmPos_q == lastB) begin
        commit   = 1'b1;
        asmPos_d = 2'h0;
      end else begin
        asmPos_d = 2'(asmPos_q + 2'h1);
      end
    end
  end

  // Assembly registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      asm_q    <= '0;
      asmPos_q <= 2'h0;
    end else begin
      asm_q    <= asm_d;
      asmPos_q <= asmPos_d;
    end
  end

  // A-to-B queue, written whole from Port A.
  pbm_queue #(
    .WIDTH       (LW),
    .AW          (DEPTH_LOG2)
  ) u_queue_ab (
    .clk         (clk),
    .rst         (rst),
    .flush       (flush[AB]),
    .fallThrough (fall_q),
    .wrEn        (portaWrEn),
    .wrData      (portaWrData),
    .popEn       (pop[AB]),
    .head        (head[AB]),
    .headValid   (headValid[AB]),
    .hasSecond   (hasSecond[AB]),
    .full        (qFull[AB]),
    .level       (qLevel[AB])
  );

  // B-to-A queue, written once per assembled long word.
  pbm_queue #(
    .WIDTH       (LW),
    .AW          (DEPTH_LOG2)
  ) u_queue_ba (
    .clk         (clk),
    .rst         (rst),
    .flush       (flush[BA]),
    .fallThrough (fall_q),
    .wrEn        (commit),
    .wrData      (commitData),
    .popEn       (pop[BA]),
    .head        (head[BA]),
    .headValid   (headValid[BA]),
    .hasSecond   (hasSecond[BA]),
    .full        (qFull[BA]),
    .level       (qLevel[BA])
  );

  // One output stage per direction: lane selection and flag timing.
  for (genvar d = 0; d < 2; d++) begin : g_reader
    always_comb begin
      logic          flag;
      logic          more;
      logic          fire;
      logic          validNext;
      logic [1:0]    idx;
      logic [LW-1:0] word;
      last[d]   = (mode[d] == pbm_pkg::SIZE_BYTE) ? pbm_pkg::LAST_BYTE :
                  (mode[d] == pbm_pkg::SIZE_WORD) ? pbm_pkg::LAST_WORD :
                  pbm_pkg::LAST_LONG;
      flag      = fall_q ? rdy_q[d] : emp_q[d];
      more      = pos_q[d] != 2'h0;
      // Fall-through refills an idle output register; standard reads on ask.
      fire      = fall_q ? ((!flag || rdReq[d]) && (more || headValid[d]))
                         : (rdReq[d] && flag);
      pop[d]    = fire && !more && !flush[d];
      word      = more ? held_q[d] : head[d];
      idx       = endian_q ? last[d] - pos_q[d] : pos_q[d];
      validNext = pop[d] ? hasSecond[d] : headValid[d];
      held_d[d] = fire ? word : held_q[d];
      // Queue words only; unused upper lines are driven zero.
      rdData_d[d] = fire ? laneGet(word, mode[d], idx) : rdData_q[d];
      pos_d[d]  = !fire ? pos_q[d] :
                  (pos_q[d] == last[d]) ? 2'h0 : 2'(pos_q[d] + 2'h1);
      // Empty flag stays up while lanes of the held word remain.
      emp_d[d]  = !fall_q && ((pos_d[d] != 2'h0) || validNext);
      // Ready falls only when the final lane goes with nothing behind it.
      rdy_d[d]  = fall_q && (fire || (flag && !rdReq[d]));
      if (flush[d]) begin
        pos_d[d] = 2'h0;
        emp_d[d] = 1'b0;
        rdy_d[d] = 1'b0;
      end
    end

    // Output stage registers, all on the one port clock.
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rdData_q[d] <= '0;
        held_q[d]   <= '0;
        pos_q[d]    <= 2'h0;
        emp_q[d]    <= 1'b0;
        rdy_q[d]    <= 1'b0;
      end else begin
        rdData_q[d] <= rdData_d[d];
        held_q[d]   <= held_d[d];
        pos_q[d]    <= pos_d[d];
        emp_q[d]    <= emp_d[d];
        rdy_q[d]    <= rdy_d[d];
      end
    end
  end

  // Port outputs, each taken from an output stage register.
  assign portbRdData      = rdData_q[AB];
  assign portbEmptyFlag   = emp_q[AB];
  assign portbOutputReady = rdy_q[AB];
  assign portaRdData      = rdData_q[BA];
  assign portaEmptyFlag   = emp_q[BA];
  assign portaOutputReady = rdy_q[BA];

endmodule // pbm_bus_match
`default_nettype wire

// file: pbm_pkg.sv
// Shared constants and types for the Port B bus-matching queue pair.
package pbm_pkg;

  // Data path widths: one long word is four nine-bit byte lanes.
  localparam int LWORD_W    = 36;
  localparam int WORD_W     = 18;
  localparam int BYTE_W     = 9;

  // Queue depth as a power of two, and the depth of the pointer delay line.
  localparam int DEPTH_LOG2  = 8;
  localparam int SYNC_STAGES = 2;

  // Register map, byte addresses on the APB.
  localparam int         APB_AW     = 8;
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LEVEL_OFS  = 8'h08;

  // Control register fields.
  localparam int CTRL_BM      = 0;
  localparam int CTRL_SIZE    = 1;
  localparam int CTRL_FALL    = 2;
  localparam int CTRL_PRST_AB = 3;
  localparam int CTRL_PRST_BA = 4;

  // Status register fields.
  localparam int ST_AB_FLAG = 0;
  localparam int ST_BA_FLAG = 1;
  localparam int ST_AB_FULL = 2;
  localparam int ST_BA_FULL = 3;
  localparam int ST_ENDIAN  = 4;
  localparam int ST_RD_POS  = 8;
  localparam int ST_ASM_POS = 12;

  // Level register field for the B-to-A queue.
  localparam int LEVEL_BA_LSB = 16;

  // Index of the last lane transfer of a long word for each bus size.
  localparam logic [1:0] LAST_LONG = 2'h0;
  localparam logic [1:0] LAST_WORD = 2'h1;
  localparam logic [1:0] LAST_BYTE = 2'h3;

  // Port B bus size.
  typedef enum logic [2:0] {
    SIZE_LONG = 3'b001,
    SIZE_WORD = 3'b010,
    SIZE_BYTE = 3'b100
  } pbm_size_t;

  // Direction indices of the two queues.
  localparam int DIR_AB = 0;
  localparam int DIR_BA = 1;

endpackage

// file: pbm_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
`default_nettype none
module pbm_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
  end

  // Both stages start from the reset value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule // pbm_sync
`default_nettype wire

// file: pbm_queue.sv
// Long-word queue memory with pointers and a delayed write pointer view.
`timescale 1ns/1ps
`default_nettype none
module pbm_queue #(
  parameter int WIDTH = pbm_pkg::LWORD_W,
  parameter int AW    = pbm_pkg::DEPTH_LOG2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             fallThrough,
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             popEn,
  output logic      [WIDTH-1:0] head,
  output logic                  headValid,
  output logic                  hasSecond,
  output logic                  full,
  output logic      [AW:0]      level
);

  localparam int S = pbm_pkg::SYNC_STAGES;

  logic [WIDTH-1:0] mem [2**AW];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      wrPtr_d;
  logic [AW:0]      rdPtr_q;
  logic [AW:0]      rdPtr_d;
  logic [AW:0]      late_q [S];
  logic [AW:0]      late_d [S];
  logic [AW:0]      seen;
  logic [AW:0]      ahead;
  logic             wrTake;

  // Occupancy and the pointer that the reading side is allowed to see.
  always_comb begin
    level     = wrPtr_q - rdPtr_q;
    full      = level[AW];
    wrTake    = wrEn && !full;
    seen      = fallThrough ? late_q[S-1] : wrPtr_q;
    ahead     = seen - rdPtr_q;
    headValid = ahead != '0;
    hasSecond = ahead > (AW+1)'(1);
    head      = mem[rdPtr_q[AW-1:0]];
  end

  // Pointer next values; the delay line stands in for the port crossing.
  always_comb begin
    wrPtr_d = flush ? '0 : (wrTake ? wrPtr_q + 1'b1 : wrPtr_q);
    rdPtr_d = flush ? '0 : ((popEn && headValid) ? rdPtr_q + 1'b1 : rdPtr_q);
    for (int i = 0; i < S; i++) begin
      late_d[i] = flush ? '0 : ((i == 0) ? wrPtr_q : late_q[(i == 0) ? 0 : i-1]);
    end
  end

  // Pointer registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      for (int i = 0; i < S; i++) begin
        late_q[i] <= '0;
      end
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      late_q  <= late_d;
    end
  end

  // Storage array, written only by accepted long words.
  always_ff @(posedge clk) begin
    if (wrTake && !flush) begin
      mem[wrPtr_q[AW-1:0]] <= wrData;
    end
  end

endmodule // pbm_queue
`default_nettype wire

// file: pbm_bus_match_asserts.sv
// Checker of bus handshake and flag timing at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module pbm_bus_match_asserts (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [pbm_pkg::APB_AW-1:0] paddr,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       portaWrEn,
  input wire logic                       portbWrEn,
  input wire logic                       portbRdEn,
  input wire logic                       portaEmptyFlag,
  input wire logic                       portaOutputReady,
  input wire logic                       portbEmptyFlag,
  input wire logic                       portbOutputReady
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h08
    |=> pslverr) else $error("no error on unmapped address");
  a_b_empty_rise: assert property (
    $rose(portbEmptyFlag) |-> $past(portaWrEn) || $past(portaWrEn, 2))
    else $error("Port B empty flag rose without a write");
  a_a_empty_rise: assert property (
    $rose(portaEmptyFlag) |-> $past(portbWrEn) || $past(portbWrEn, 2))
    else $error("Port A empty flag rose without a write");
  a_b_ready_rise: assert property (
    $rose(portbOutputReady) |-> $past(portaWrEn, 3) || $past(portaWrEn, 4))
    else $error("Port B ready rose off the fall-through time");
  a_a_ready_rise: assert property (
    $rose(portaOutputReady) |-> $past(portbWrEn, 3) || $past(portbWrEn, 4))
    else $error("Port A ready rose off the fall-through time");
  a_b_flag_fall: assert property (
    $fell(portbEmptyFlag || portbOutputReady) |-> $past(portbRdEn))
    else $error("Port B flag fell without a read");

  cover property ($rose(portbOutputReady));
  cover property ($rose(portaEmptyFlag));
  cover property (pslverr);
endmodule // pbm_bus_match_asserts

bind pbm_bus_match pbm_bus_match_asserts chk_u (.clk, .rst, .psel,
  .penable, .paddr, .pready, .pslverr, .portaWrEn, .portbWrEn, .portbRdEn,
  .portaEmptyFlag, .portaOutputReady, .portbEmptyFlag, .portbOutputReady);
`default_nettype wire

// file: pbm_host_a.sv
// Port A host model: writes long words on request and reads at random.
`timescale 1ns/1ps
`default_nettype none
module pbm_host_a (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [35:0] word,
  output logic             wrEn,
  output logic      [35:0] wrData,
  output logic             rdEn
);
  int seed = 14518;

  // Idle data is inverted so a stale word never looks valid.
  always @(posedge clk) begin
    wrEn   <= go;
    wrData <= go ? word : ~word;
    rdEn   <= 1'($random(seed));
  end
endmodule // pbm_host_a
`default_nettype wire

// file: pbm_bus_match_tb.sv
// Self-checking bench for the Port B bus-matching queue pair.
`timescale 1ns/1ps
`default_nettype none
module pbm_bus_match_tb;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, go, e;
  logic        masterResetOneN, masterResetTwoN, endianSelect, be, fall;
  logic        portaWrEn, portaRdEn, portaEmptyFlag, portaOutputReady;
  logic        portbWrEn, portbRdEn, portbEmptyFlag, portbOutputReady;
  logic        tkA, tkB;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [35:0] word, w, msk, portaWrData, portaRdData;
  logic [35:0] portbWrData, portbRdData, expA[$], expB[$];
  int          m, cyc, failCount, comparisons, seed = 14518;

  pbm_bus_match #(.DEPTH_LOG2(3)) dut_u (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .masterResetOneN,
    .masterResetTwoN, .endianSelect, .portaWrEn, .portaWrData, .portaRdEn,
    .portaRdData, .portaEmptyFlag, .portaOutputReady, .portbWrEn,
    .portbWrData, .portbRdEn, .portbRdData, .portbEmptyFlag,
    .portbOutputReady);
  pbm_host_a host_u (.clk, .go, .word, .wrEn(portaWrEn),
    .wrData(portaWrData), .rdEn(portaRdEn));

  // The clock toggles every 50 ns, a full period of 100 ns.
  always #50 clk = ~clk;

  // Lane k of a long word in transfer order for this size and endian.
  function automatic logic [35:0] lane(input logic [35:0] v, input int k);
    int n = 1 << m;
    int i = be ? n - 1 - k : k;
    return (v >> (i * (36 / n))) & msk;
  endfunction

  // Compares a seen value with the expected one and counts both.
  task automatic chk(input logic [35:0] seen, exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // Let an edge pass so a following call never drives psel twice at once.
    @(posedge clk);
  endtask

  // Takes the oldest note off a queue whenever a result is delivered.
  always @(posedge clk) begin
    if (fall ? portbOutputReady && portbRdEn : tkB)
      chk(portbRdData & msk, expB.pop_front(), "portB");
    if (fall ? portaOutputReady && portaRdEn : tkA)
      chk(portaRdData, expA.pop_front(), "portA");
    tkB = portbEmptyFlag && portbRdEn;
    tkA = portaEmptyFlag && portaRdEn;
  end

  // Random Port B reads, and a ceiling on the run length.
  always @(posedge clk) begin
    portbRdEn <= 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failCount++;
      complete_run();
    end
  end

  // Main sequence: one pass per size, endian and flag mode.
  initial begin
    {clk, psel, penable, pwrite, go, portbWrEn, portbRdEn, fall} = '0;
    {masterResetOneN, masterResetTwoN, endianSelect, be} = '0;
    {paddr, pwdata, word, portbWrData, msk} = '0;
    rst = 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int c = 0; c < 12; c++) begin
      m = c % 3;
      be = 1'((c / 3) % 2);
      fall = 1'(c / 6);
      msk = m == 0 ? '1 : (m == 1 ? 36'h3ffff : 36'h1ff);
      masterResetOneN <= 0;
      masterResetTwoN <= 0;
      endianSelect <= be;
      repeat (2) @(posedge clk);
      masterResetOneN <= 1;
      masterResetTwoN <= 1;
      repeat (3) @(posedge clk);
      apb(1, 8'h00, {29'h0, fall, m == 2, m != 0});
      apb(0, 8'h04, 32'h0);
      chk(r[4], be, "endian");
      apb(0, 8'h10, 32'h0);
      chk(e, 1'b1, "pslverr");
      for (int k = 0; k < 3; k++) begin
        w = {4'($random(seed)), 32'($random(seed))};
        go <= 1;
        word <= w;
        for (int j = 0; j < (1 << m); j++) expB.push_back(lane(w, j));
        @(posedge clk);
      end
      go <= 0;
      for (int k = 0; k < 3; k++) begin
        w = {4'($random(seed)), 32'($random(seed))};
        expA.push_back(w);
        for (int j = 0; j < (1 << m); j++) begin
          portbWrEn <= 1;
          portbWrData <= lane(w, j) | (~msk & word);
          @(posedge clk);
        end
      end
      portbWrEn <= 0;
      for (int t = 0; t < 300 && expA.size() + expB.size() > 0; t++)
        @(posedge clk);
      chk(36'(expA.size() + expB.size()), 36'h0, "left");
      if (m != 0) begin
        // One stray lane is gathered, then a partial reset must drop it.
        portbWrEn <= 1;
        @(posedge clk);
        portbWrEn <= 0;
        apb(0, 8'h04, 32'h0);
        chk(36'(r[13:12]), 36'h1, "asmPos");
        apb(1, 8'h00, {27'h0, 2'b11, fall, m == 2, 1'b1});
        apb(0, 8'h04, 32'h0);
        chk(36'(r[13:12]), 36'h0, "asmDrop");
      end
      expA.delete();
      expB.delete();
      $display("test %0d size %0d endian %0d fall %0d done", c, m, be, fall);
    end
    complete_run();
  end
endmodule // pbm_bus_match_tb
`default_nettype wire
